// >>> logic/count_timer_pkg.sv
/*
 Shared constants for the count timer and its interrupt acceptance logic.
 Assumes an 8-bit register port and an 11-bit processor address space.
*/
`default_nettype none
package count_timer_pkg;
	// Register map
	localparam logic [10:0] COUNT_VALUE_ADDR   = 11'h008;
	localparam logic [10:0] COUNT_CONTROL_ADDR = 11'h009;
	// Control register fields
	localparam int ZERO_FLAG_BIT   = 7;
	localparam int IRQ_MASK_BIT    = 6;
	localparam int SOURCE_BIT      = 5;
	localparam int PIN_ENABLE_BIT  = 4;
	localparam int DIV_CLEAR_BIT   = 3;
	localparam int DIV_SELECT_HI   = 2;
	localparam int DIV_SELECT_LO   = 0;
	// Option byte fields
	localparam int LEGACY_OPT_BIT  = 6;
	// Reset values
	localparam logic ZERO_FLAG_RESET = 1'b0;
	localparam logic IRQ_MASK_RESET  = 1'b1;
	localparam logic GLOBAL_MASK_RESET = 1'b1;
	// Timing
	localparam int CLK_PERIOD_NS     = 10;
	localparam int MACHINE_DIV       = 4;
	localparam int MACHINE_CYCLE_NS  = CLK_PERIOD_NS * MACHINE_DIV;
	localparam int RESET_HOLD_CYCLES = (MACHINE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
	localparam logic [1:0] MACHINE_LAST = 2'(MACHINE_DIV - 1);
	// Prescaler
	localparam int DIV_WIDTH = 7;
	// Interrupt sources
	typedef enum logic [1:0] {src_none, src_external, src_timer, src_trap} irq_src_t;
	// Prescaler input modes
	typedef enum logic [1:0] {mode_internal, mode_gated, mode_off, mode_external} input_mode_t;
endpackage
`default_nettype wire

// >>> logic/level_sync.sv
/*
 Two-stage synchroniser for levels arriving from outside the clock domain.
 Assumes inputs are slow compared with the clock.
*/
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
	parameter int WIDTH = 1
) (
	// Clock and control
	input  wire logic             ref_clk_in,
	input  wire logic             rstn_in,
	input  wire logic             ce_in,
	// Level
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;

	// First stage feeds only the second
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else if (ce_in) begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule
`default_nettype wire

// >>> logic/divider_chain.sv
/*
 Seven-bit clearable prescaler with a selectable power-of-two output tap.
 Assumes tick_in is a one-cycle strobe on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module divider_chain
	import count_timer_pkg::*;
#(
	parameter int WIDTH = DIV_WIDTH
) (
	// Clock and control
	input  wire logic       ref_clk_in,
	input  wire logic       rstn_in,
	input  wire logic       ce_in,
	// Divider control
	input  wire logic       clear_in,
	input  wire logic       tick_in,
	input  wire logic [2:0] select_in,
	// Divided strobe
	output logic            tick_out
);
	logic [WIDTH-1:0] stage_reg;
	logic [WIDTH-1:0] stage_next;
	logic             tap_hit;

	function automatic logic [WIDTH-1:0] tap_mask(input logic [2:0] sel);
		tap_mask = WIDTH'((1 << sel) - 1);
	endfunction

	always_comb begin
		stage_next = stage_reg + WIDTH'(1);
		tap_hit    = (select_in == 3'h0) || ((stage_reg & tap_mask(select_in)) == tap_mask(select_in));
	end

	// Clear beats a coincident tick, so no truncated period follows a clear
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			stage_reg <= '0;
		end else if (ce_in) begin
			if (clear_in) begin
				stage_reg <= '0; // [R7]
			end else if (tick_in) begin
				stage_reg <= stage_next;
			end
		end
	end

	// Ratio 1 for code 0, else two to the code
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			tick_out <= 1'b0;
		end else if (ce_in) begin
			tick_out <= tick_in && !clear_in && tap_hit; // [R23]
		end
	end
endmodule
`default_nettype wire

// >>> logic/count_timer.sv
/*
 Eight-bit down counter with prescaler, input modes, zero flag and the
 processor-side interrupt acceptance (global mask, external latch, trap).
 Assumes the core pulses instr_done_in at each instruction boundary and
 holds option_byte_in steady; timer and interrupt pins are asynchronous.
*/
// Behaviour
// [R1] Eight-bit counter, loadable by software, decrements on each prescaled tick.
// [R2] Step from 01 to 00 sets the zero flag, control bit 7.
// [R3] Interrupt servicing leaves the zero flag; only software or reset clears it.
// [R4] Counter interrupt reaches processor only with counter mask and global mask clear.
// [R5] Counter wraps from 00 to ff and keeps counting down.
// [R6] Counter readable any time without disturbance; reset leaves it unchanged.
// [R7] Writing 1 to control bit 3 clears prescaler; bit 3 reads 0.
// [R8] Mode bits 5:4 both zero: internal clock, count pin ignored.
// [R9] Pin enable 1, source 0: internal clock ANDed with count pin.
// [R10] Pin enable 0, source 1: no prescaler input, counter disabled.
// [R11] Both bits set: prescaler clocked by the external count pin.
// [R12] Internal count clock is oscillator divided by four.
// [R13] Legacy option: bits 5,2,1,0 loaded from option byte, not writable.
// [R14] Legacy option: control bits 4 and 3 read as 1.
// [R15] Any reset clears the zero flag.
// [R16] External interrupt pin synchronised, falling edge latched, held while masked.
// [R17] Masked counter request vanishes if software clears the flag first.
// [R18] Hardware requests are checked only at instruction boundaries.
// [R19] Acceptance pushes state, sets global mask, loads vector.
// [R20] External request beats counter request at the same boundary.
// [R21] Software trap runs regardless of global mask, entered like interrupts.
// [R22] Outside party holds reset low longer than one machine cycle.
// [R23] Select code picks ratio 1 to 128; code 0 bypasses prescaler.
// [R24] Counter mask bit resets to 1.
`timescale 1ns/1ps
`default_nettype none
module count_timer
	import count_timer_pkg::*;
#(
	parameter logic [10:0] EXT_VECTOR   = 11'h7fa,
	parameter logic [10:0] TIMER_VECTOR = 11'h7f8,
	parameter logic [10:0] TRAP_VECTOR  = 11'h7fc
) (
	// Clock, reset, enable
	input  wire logic        ref_clk_in,
	input  wire logic        rstn_in,
	input  wire logic        ce_in,
	// Register port
	input  wire logic [10:0] addr_in,
	input  wire logic [7:0]  wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	output logic      [7:0]  rdata_out,
	// Option byte strap
	input  wire logic [7:0]  option_byte_in,
	// Pins
	input  wire logic        count_pin_in,
	input  wire logic        ext_irq_pin_in,
	// Core side
	input  wire logic        instr_done_in,
	input  wire logic        soft_trap_in,
	input  wire logic        mask_clear_in,
	input  wire logic        mask_set_in,
	output logic             accept_out,
	output irq_src_t         accept_src_out,
	output logic      [10:0] vector_out,
	output logic             global_mask_out
);
	// Control state
	logic        zero_flag_reg;
	logic        irq_mask_reg;
	logic        source_reg;
	logic        pin_enable_reg;
	logic [2:0]  select_reg;
	logic        legacy_reg;
	logic [7:0]  count_reg;
	logic [1:0]  machine_reg;
	logic        ext_pend_reg;
	logic        trap_pend_reg;
	logic        pin_prev_reg;
	logic        irq_prev_reg;
	// Combinational, plus registered outputs of the submodules
	logic        count_pin_sync;
	logic        irq_pin_sync;
	logic        machine_tick;
	logic        pre_tick;
	logic        div_tick;
	logic        div_clear;
	logic        wr_control;
	logic        wr_count;
	logic        timer_req;
	logic        take_ext;
	logic        take_timer;
	logic        take_trap;
	logic        eff_pin_enable;
	input_mode_t mode;
	logic [7:0]  control_view;

	function automatic input_mode_t decode_mode(input logic pin_en, input logic src);
		case ({pin_en, src})
			2'b00:   decode_mode = mode_internal;
			2'b10:   decode_mode = mode_gated;
			2'b01:   decode_mode = mode_off;
			2'b11:   decode_mode = mode_external;
			default: decode_mode = mode_off;
		endcase
	endfunction

	level_sync #(
		.WIDTH(2)
	) u_pin_sync (
		.ref_clk_in (ref_clk_in),
		.rstn_in    (rstn_in),
		.ce_in      (ce_in),
		.async_in   ({count_pin_in, ext_irq_pin_in}),
		.sync_out   ({count_pin_sync, irq_pin_sync}) // [R16]
	);

	divider_chain #(
		.WIDTH(DIV_WIDTH)
	) u_divider (
		.ref_clk_in (ref_clk_in),
		.rstn_in    (rstn_in),
		.ce_in      (ce_in),
		.clear_in   (div_clear),
		.tick_in    (pre_tick),
		.select_in  (select_reg),
		.tick_out   (div_tick)
	);

	// Legacy mode forces the pin enable on
	always_comb begin
		wr_control     = wr_in && (addr_in == COUNT_CONTROL_ADDR);
		wr_count       = wr_in && (addr_in == COUNT_VALUE_ADDR);
		div_clear      = wr_control && !legacy_reg && wdata_in[DIV_CLEAR_BIT]; // [R7]
		eff_pin_enable = legacy_reg ? 1'b1 : pin_enable_reg;
		mode           = decode_mode(eff_pin_enable, source_reg);
		machine_tick   = (machine_reg == MACHINE_LAST); // [R12]
		case (mode)
			mode_internal: pre_tick = machine_tick; // [R8]
			mode_gated:    pre_tick = machine_tick && count_pin_sync; // [R9]
			mode_off:      pre_tick = 1'b0; // [R10]
			mode_external: pre_tick = count_pin_sync && !pin_prev_reg; // [R11]
			default:       pre_tick = 1'b0;
		endcase
	end

	// Machine cycle divider
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			machine_reg <= 2'h0;
		end else if (ce_in) begin
			machine_reg <= machine_tick ? 2'h0 : machine_reg + 2'h1; // [R12]
		end
	end

	// Edge history of synchronised pins
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			pin_prev_reg <= 1'b0;
			irq_prev_reg <= 1'b0;
		end else if (ce_in) begin
			pin_prev_reg <= count_pin_sync;
			irq_prev_reg <= irq_pin_sync;
		end
	end

	// Configuration bits; strap sampled while reset is held
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			legacy_reg     <= option_byte_in[LEGACY_OPT_BIT];
			source_reg     <= option_byte_in[SOURCE_BIT]; // [R13]
			pin_enable_reg <= option_byte_in[PIN_ENABLE_BIT];
			select_reg     <= option_byte_in[DIV_SELECT_HI:DIV_SELECT_LO];
		end else if (ce_in && wr_control && !legacy_reg) begin
			source_reg     <= wdata_in[SOURCE_BIT];
			pin_enable_reg <= wdata_in[PIN_ENABLE_BIT];
			select_reg     <= wdata_in[DIV_SELECT_HI:DIV_SELECT_LO];
		end
	end

	// Mask bit stays writable in both modes
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			irq_mask_reg <= IRQ_MASK_RESET; // [R24]
		end else if (ce_in && wr_control) begin
			irq_mask_reg <= wdata_in[IRQ_MASK_BIT];
		end
	end

	// No reset: elapsed time since the last zero survives a reset
	always_ff @(posedge ref_clk_in) begin
		if (ce_in) begin
			if (wr_count) begin
				count_reg <= wdata_in; // [R1]
			end else if (div_tick) begin
				count_reg <= count_reg - 8'h01; // [R1] [R5] [R6]
			end
		end
	end

	// Hardware set beats a software clear in the same cycle
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			zero_flag_reg <= ZERO_FLAG_RESET; // [R15]
		end else if (ce_in) begin
			if (div_tick && !wr_count && count_reg == 8'h01) begin
				zero_flag_reg <= 1'b1; // [R2]
			end else if (wr_control) begin
				zero_flag_reg <= wdata_in[ZERO_FLAG_BIT]; // [R3]
			end
		end
	end

	always_comb begin
		control_view = {zero_flag_reg, irq_mask_reg, source_reg, eff_pin_enable, legacy_reg, select_reg}; // [R7] [R14]
	end

	// Read data valid the cycle after the strobe only
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			rdata_out <= 8'h00;
		end else if (ce_in) begin
			if (rd_in && addr_in == COUNT_CONTROL_ADDR) begin
				rdata_out <= control_view;
			end else if (rd_in && addr_in == COUNT_VALUE_ADDR) begin
				rdata_out <= count_reg; // [R6]
			end else begin
				rdata_out <= 8'h00;
			end
		end
	end

	// Interrupt acceptance at the boundary, fixed priority
	always_comb begin
		timer_req  = zero_flag_reg && !irq_mask_reg; // [R4] [R17]
		take_ext   = instr_done_in && !global_mask_out && ext_pend_reg; // [R18] [R20]
		take_timer = instr_done_in && !global_mask_out && !ext_pend_reg && timer_req; // [R4] [R18]
		take_trap  = instr_done_in && !take_ext && !take_timer && trap_pend_reg; // [R21]
	end

	// New falling edge wins over the acceptance clear
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			ext_pend_reg <= 1'b0;
		end else if (ce_in) begin
			if (irq_prev_reg && !irq_pin_sync) begin
				ext_pend_reg <= 1'b1; // [R16]
			end else if (take_ext) begin
				ext_pend_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			trap_pend_reg <= 1'b0;
		end else if (ce_in) begin
			if (soft_trap_in) begin
				trap_pend_reg <= 1'b1;
			end else if (take_trap) begin
				trap_pend_reg <= 1'b0;
			end
		end
	end

	// Acceptance sets the mask even against a coincident clear
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			global_mask_out <= GLOBAL_MASK_RESET;
		end else if (ce_in) begin
			if (take_ext || take_timer || take_trap || mask_set_in) begin
				global_mask_out <= 1'b1; // [R19]
			end else if (mask_clear_in) begin
				global_mask_out <= 1'b0;
			end
		end
	end

	// Core pushes state on accept_out; the zero flag is left alone
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			accept_out     <= 1'b0;
			accept_src_out <= src_none;
			vector_out     <= 11'h000;
		end else if (ce_in) begin
			accept_out <= take_ext || take_timer || take_trap; // [R19]
			if (take_ext) begin
				accept_src_out <= src_external;
				vector_out     <= EXT_VECTOR;
			end else if (take_timer) begin
				accept_src_out <= src_timer; // [R3]
				vector_out     <= TIMER_VECTOR;
			end else if (take_trap) begin
				accept_src_out <= src_trap;
				vector_out     <= TRAP_VECTOR;
			end
		end
	end

	// Assertions
	a_zero_flag_set: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // [R2]
		ce_in && div_tick && !wr_count && count_reg == 8'h01 |=> zero_flag_reg && count_reg == 8'h00)
		else $error("zero flag not set on step to zero");
	a_count_wraps: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // [R5]
		ce_in && div_tick && !wr_count && count_reg == 8'h00 |=> count_reg == 8'hff)
		else $error("counter did not wrap to ff");
	a_clear_reads_zero: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // [R7]
		ce_in && rd_in && addr_in == COUNT_CONTROL_ADDR && !legacy_reg |=> rdata_out[DIV_CLEAR_BIT] == 1'b0)
		else $error("prescaler clear bit read nonzero");
	a_legacy_reads_ones: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // [R14]
		ce_in && rd_in && addr_in == COUNT_CONTROL_ADDR && legacy_reg |=> rdata_out[4:3] == 2'b11)
		else $error("legacy bits 4 and 3 not read as one");
	a_timer_gated: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // [R4]
		ce_in && (irq_mask_reg || !zero_flag_reg || global_mask_out)
		|=> !(accept_out && accept_src_out == src_timer))
		else $error("counter interrupt taken while masked");
	a_ext_first: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // [R20]
		ce_in && instr_done_in && !global_mask_out && ext_pend_reg && timer_req
		|=> accept_out && accept_src_out == src_external)
		else $error("external request not serviced first");
	a_boundary_only: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // [R18]
		ce_in && !instr_done_in |=> !accept_out)
		else $error("interrupt accepted mid instruction");
	a_accept_masks: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // [R19]
		accept_out |-> global_mask_out && vector_out != 11'h000)
		else $error("accept without mask set or vector");
	a_trap_unmasked: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // [R21]
		ce_in && instr_done_in && trap_pend_reg && global_mask_out && !soft_trap_in
		|=> accept_out && accept_src_out == src_trap)
		else $error("trap blocked by global mask");
	a_off_mode_idle: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // [R10]
		ce_in && mode == mode_off |=> !div_tick)
		else $error("prescaler fed while disabled");
	a_legacy_locked: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // [R13]
		ce_in && wr_control && legacy_reg |=> $stable(select_reg) && $stable(source_reg))
		else $error("legacy configuration bits changed by write");

	c_timer_taken: cover property (@(posedge ref_clk_in) accept_out && accept_src_out == src_timer);
	c_ext_taken: cover property (@(posedge ref_clk_in) accept_out && accept_src_out == src_external);
	c_trap_taken: cover property (@(posedge ref_clk_in) accept_out && accept_src_out == src_trap);
	c_wrap: cover property (@(posedge ref_clk_in) div_tick && count_reg == 8'h00);
	c_gated_tick: cover property (@(posedge ref_clk_in) mode == mode_gated && pre_tick);
endmodule
`default_nettype wire

// >>> dv/core_model.sv
/*
 Processor core stand-in: instruction boundary pulses and acceptance order watch.
 Assumes accept_in is the timer block's registered one-cycle acceptance pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module core_model (
	// Clock and reset
	input  wire logic ref_clk_in,
	input  wire logic rstn_in,
	// Acceptance from block
	input  wire logic accept_in,
	// Boundary and order error
	output logic      instr_done_out,
	output logic      order_err_out
);
	logic [1:0] phase_reg;
	logic       done_d_reg;
	// Four-clock instructions, one boundary each
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			phase_reg      <= 2'h0;
			instr_done_out <= 1'b0;
			done_d_reg     <= 1'b0;
		end else begin
			phase_reg      <= phase_reg + 2'h1;
			instr_done_out <= (phase_reg == 2'h3);
			done_d_reg     <= instr_done_out;
		end
	end
	// Sticky, so a late check still sees it
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in)
			order_err_out <= 1'b0;
		else if (accept_in && !done_d_reg)
			order_err_out <= 1'b1;
	end
endmodule
`default_nettype wire

// >>> dv/timer_prescaler_interrupt_bench.sv
/*
 Self-checking bench for the count timer: register tasks and sequences.
 Assumes core_model supplies instruction boundaries; bench drives pins.
*/
`timescale 1ns/1ps
`default_nettype none
module timer_prescaler_interrupt_bench;
	import count_timer_pkg::*;
	logic        ref_clk_in, rstn_in, wr_in, rd_in, count_pin_in, ext_irq_pin_in;
	logic        soft_trap_in, mask_clear_in, mask_set_in, instr_done_in, order_err, ce_in;
	logic        accept_out, global_mask_out;
	logic [10:0] addr_in, vector_out;
	logic [7:0]  wdata_in, rdata_out, option_byte_in, d, e;
	irq_src_t    accept_src_out;
	int          err_total, checks_done, cyc;

	count_timer dut_u (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .ce_in(ce_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
		.option_byte_in(option_byte_in), .count_pin_in(count_pin_in), .ext_irq_pin_in(ext_irq_pin_in),
		.instr_done_in(instr_done_in), .soft_trap_in(soft_trap_in), .mask_clear_in(mask_clear_in),
		.mask_set_in(mask_set_in), .accept_out(accept_out), .accept_src_out(accept_src_out),
		.vector_out(vector_out), .global_mask_out(global_mask_out));
	core_model core_u (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .accept_in(accept_out),
		.instr_done_out(instr_done_in), .order_err_out(order_err));

	always #5 ref_clk_in = ~ref_clk_in;

	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Hang guard, run needs well under this
	always @(posedge ref_clk_in) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			final_report();
		end
	end
	task automatic chk(input string name, input logic [10:0] exp, input logic [10:0] got);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	// Range, for counts that start on an unknown tick phase
	task automatic chk_range(input string name, input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] got);
		checks_done++;
		if ($isunknown(got) || got < lo || got > hi) begin
			err_total++;
			$display("[FAIL] %s expected %h to %h seen %h", name, lo, hi, got);
		end
	endtask
	task automatic reg_wr(input logic [10:0] a, input logic [7:0] v);
		@(posedge ref_clk_in);
		addr_in  <= a;
		wdata_in <= v;
		wr_in    <= 1'b1;
		@(posedge ref_clk_in);
		wr_in    <= 1'b0;
	endtask
	task automatic reg_rd(input logic [10:0] a, output logic [7:0] v);
		@(posedge ref_clk_in);
		addr_in <= a;
		rd_in   <= 1'b1;
		@(posedge ref_clk_in);
		rd_in   <= 1'b0;
		#1;
		v = rdata_out;
	endtask
	task automatic rd_chk(input string name, input logic [10:0] a, input logic [7:0] exp);
		logic [7:0] v;
		reg_rd(a, v);
		chk(name, {3'h0, exp}, {3'h0, v});
	endtask
	task automatic reset_dut(input logic [7:0] opt);
		@(posedge ref_clk_in);
		option_byte_in <= opt;
		rstn_in        <= 1'b0;
		repeat (5) @(posedge ref_clk_in);
		rstn_in        <= 1'b1;
	endtask
	task automatic pin_edges(input int n);
		repeat (n) begin
			@(posedge ref_clk_in);
			count_pin_in <= 1'b1;
			repeat (8) @(posedge ref_clk_in);
			count_pin_in <= 1'b0;
			repeat (8) @(posedge ref_clk_in);
		end
	endtask
	task automatic clr_mask();
		@(posedge ref_clk_in);
		mask_clear_in <= 1'b1;
		@(posedge ref_clk_in);
		mask_clear_in <= 1'b0;
	endtask
	task automatic wait_accept(input irq_src_t src, input logic [10:0] vec);
		int n;
		n = 0;
		while (accept_out !== 1'b1 && n < 40) begin
			@(posedge ref_clk_in);
			#1;
			n++;
		end
		chk("accept", 11'h1, {10'h0, accept_out});
		chk("source", {9'h0, src}, {9'h0, accept_src_out});
		chk("vector", vec, vector_out);
		chk("global mask", 11'h1, {10'h0, global_mask_out});
		@(posedge ref_clk_in);
	endtask
	task automatic no_accept();
		logic seen;
		seen = 1'b0;
		repeat (24) begin
			@(posedge ref_clk_in);
			#1;
			seen = seen | (accept_out !== 1'b0);
		end
		chk("no accept", 11'h0, {10'h0, seen});
	endtask

	initial begin
		ref_clk_in = 0; rstn_in = 0; wr_in = 0; rd_in = 0; addr_in = 0; wdata_in = 0;
		count_pin_in = 0; ext_irq_pin_in = 1; soft_trap_in = 0; mask_clear_in = 0; mask_set_in = 0;
		option_byte_in = 0; err_total = 0; checks_done = 0; cyc = 0;
		ce_in = 1;
		reset_dut(8'h00);
		rd_chk("control reset", COUNT_CONTROL_ADDR, 8'h40);
		rd_chk("unmapped", 11'h00a, 8'h00);
		// Internal clock, pin low must not stop it
		reg_wr(COUNT_VALUE_ADDR, 8'h20);
		repeat (40) @(posedge ref_clk_in);
		reg_rd(COUNT_VALUE_ADDR, d);
		chk_range("internal count", 8'h15, 8'h17, d);
		// Enable low freezes the count; at most one tick in the unfrozen edges
		@(posedge ref_clk_in);
		ce_in <= 1'b0;
		repeat (40) @(posedge ref_clk_in);
		ce_in <= 1'b1;
		reg_rd(COUNT_VALUE_ADDR, e);
		chk_range("frozen count", d - 8'h01, d, e);
		reg_wr(COUNT_VALUE_ADDR, 8'h03);
		d = 8'h00;
		for (int i = 0; i < 20 && d[7] !== 1'b1; i++)
			reg_rd(COUNT_CONTROL_ADDR, d);
		chk("zero flag", 11'h0c0, {3'h0, d});
		repeat (40) @(posedge ref_clk_in);
		reg_rd(COUNT_VALUE_ADDR, d);
		chk_range("wrap", 8'hf3, 8'hfe, d);
		// Counter off, flag set, counter mask open, global mask still set
		reg_wr(COUNT_CONTROL_ADDR, 8'ha0);
		no_accept();
		clr_mask();
		wait_accept(src_timer, 11'h7f8);
		rd_chk("flag after accept", COUNT_CONTROL_ADDR, 8'ha0);
		// Falling edge while masked, timer also pending
		@(posedge ref_clk_in);
		ext_irq_pin_in <= 1'b0;
		repeat (10) @(posedge ref_clk_in);
		clr_mask();
		wait_accept(src_external, 11'h7fa);
		clr_mask();
		wait_accept(src_timer, 11'h7f8);
		ext_irq_pin_in <= 1'b1;
		// Flag cleared before unmasking drops the request
		reg_wr(COUNT_CONTROL_ADDR, 8'he0);
		reg_wr(COUNT_CONTROL_ADDR, 8'h20);
		clr_mask();
		no_accept();
		@(posedge ref_clk_in);
		mask_set_in <= 1'b1;
		@(posedge ref_clk_in);
		mask_set_in <= 1'b0;
		@(posedge ref_clk_in);
		#1;
		chk("mask set", 11'h1, {10'h0, global_mask_out});
		@(posedge ref_clk_in);
		soft_trap_in <= 1'b1;
		@(posedge ref_clk_in);
		soft_trap_in <= 1'b0;
		wait_accept(src_trap, 11'h7fc);
		chk("boundary order", 11'h0, {10'h0, order_err});
		// Disabled mode holds the count
		reg_wr(COUNT_CONTROL_ADDR, 8'h60);
		reg_wr(COUNT_VALUE_ADDR, 8'h05);
		repeat (60) @(posedge ref_clk_in);
		rd_chk("disabled", COUNT_VALUE_ADDR, 8'h05);
		// Gated: pin low holds, pin high counts
		reg_wr(COUNT_CONTROL_ADDR, 8'h50);
		repeat (60) @(posedge ref_clk_in);
		rd_chk("gate closed", COUNT_VALUE_ADDR, 8'h05);
		count_pin_in <= 1'b1;
		repeat (40) @(posedge ref_clk_in);
		reg_rd(COUNT_VALUE_ADDR, d);
		chk_range("gate open", 8'hf9, 8'hfd, d);
		count_pin_in <= 1'b0;
		// External events, then ratio two after a clear
		reg_wr(COUNT_CONTROL_ADDR, 8'h70);
		reg_wr(COUNT_VALUE_ADDR, 8'h0a);
		pin_edges(3);
		rd_chk("external", COUNT_VALUE_ADDR, 8'h07);
		reg_wr(COUNT_CONTROL_ADDR, 8'h79);
		rd_chk("clear reads 0", COUNT_CONTROL_ADDR, 8'h71);
		reg_wr(COUNT_VALUE_ADDR, 8'h0a);
		pin_edges(4);
		rd_chk("ratio two", COUNT_VALUE_ADDR, 8'h08);
		// Legacy strap, count survives reset
		reg_wr(COUNT_CONTROL_ADDR, 8'ha0);
		reg_wr(COUNT_VALUE_ADDR, 8'h5a);
		reset_dut(8'h45);
		rd_chk("legacy control", COUNT_CONTROL_ADDR, 8'h5d);
		rd_chk("count kept", COUNT_VALUE_ADDR, 8'h5a);
		reg_wr(COUNT_CONTROL_ADDR, 8'h27);
		rd_chk("legacy locked", COUNT_CONTROL_ADDR, 8'h1d);
		final_report();
	end
endmodule
`default_nettype wire
